// ==== src/fsr_poller.sv ====
// host-side controller that polls flash operation status over the flash pins
`timescale 1ns/1ps
`default_nettype none
module fsr_poller
   import fsr_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              rst,
   input  wire logic              poll_start,
   input  wire logic              poll_abort,
   input  wire logic              win_check,
   input  wire logic              cmd_valid,
   input  wire logic [ADDR_W-1:0] cmd_addr,
   input  wire logic [DATA_W-1:0] cmd_data,
   input  wire logic              rd_valid,
   input  wire logic [ADDR_W-1:0] user_addr,
   input  wire logic [DATA_W-1:0] dq_in,
   input  wire logic              ready_busy_in,
   output logic                   flash_ce_n,
   output logic                   flash_oe_n,
   output logic                   flash_we_n,
   output logic [ADDR_W-1:0]      flash_addr,
   output logic [DATA_W-1:0]      dq_out,
   output logic                   dq_oe,
   output logic                   busy,
   output logic                   done,
   output logic [1:0]             result,
   output logic [DATA_W-1:0]      rd_data,
   output logic                   window_open,
   output logic                   flash_ready
);
   // whole state of the controller except the input synchronisers
   typedef struct packed {
      fsr_state_e        st;
      logic [DATA_W-1:0] first;     // status byte of the earlier read
      logic [ADDR_W-1:0] addr;      // polled address
      logic              win_pre;   // window flag before an added erase
      logic              restart;   // abort seen, resume from the double read
      logic              busy;
      logic              done;
      fsr_result_e       result;
      logic [DATA_W-1:0] rd_data;
      logic              window_open;
      logic              flash_ready;
   } fsr_ctl_s;

   fsr_ctl_s q;        // registered state
   fsr_ctl_s next_q;   // next state

   // synchronisers for the pin inputs
   logic [DATA_W-1:0] dq_m, dq_s;
   logic              rb_m, rb_s;

   // cycle engine handshake
   logic              cyc_start;
   logic              cyc_write;
   logic [ADDR_W-1:0] cyc_addr;
   logic [DATA_W-1:0] cyc_wdata;
   fsr_pins_s         pins;
   logic [DATA_W-1:0] cyc_rdata;
   logic              cyc_done;
   logic              toggling;    // toggle bit differs between two reads

   ////////////////////////////////////////////////////////////////////////
   // input synchronisers; pins are asynchronous to mclk
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         dq_m <= '0;
         dq_s <= '0;
         rb_m <= 1'b1;
         rb_s <= 1'b1;
      end
      else
      begin
         dq_m <= dq_in;
         dq_s <= dq_m;
         rb_m <= ready_busy_in;
         rb_s <= rb_m;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // bus cycle engine
   fsr_cycle fsr_cycle_i (
      .mclk    (mclk),
      .rst     (rst),
      .start   (cyc_start),
      .write   (cyc_write),
      .addr    (cyc_addr),
      .wdata   (cyc_wdata),
      .dq_sync (dq_s),
      .pins    (pins),
      .rdata   (cyc_rdata),
      .done    (cyc_done)
   );

   assign toggling = cyc_rdata[POS_TOGGLE] ^ q.first[POS_TOGGLE];

   ////////////////////////////////////////////////////////////////////////
   // issue request to the engine from the current state
   always_comb
   begin
      cyc_start = 1'b0;
      cyc_write = 1'b0;
      cyc_addr  = q.addr;
      cyc_wdata = RESET_CMD;
      case (q.st)
         ST_RD1, ST_RD2, ST_RD3, ST_WIN, ST_ARRAY:
            cyc_start = 1'b1;
         ST_RST:
         begin
            cyc_start = 1'b1;
            cyc_write = 1'b1;
         end
         ST_WRC:
         begin
            cyc_start = 1'b1;
            cyc_write = 1'b1;
            cyc_wdata = q.rd_data;
         end
         default:
            cyc_start = 1'b0;
      endcase
      // engine is idle in its done cycle; hold off so no stray cycle starts
      if (cyc_done)
         cyc_start = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // polling sequence
   always_comb
   begin
      next_q             = q;
      next_q.done        = 1'b0;
      next_q.flash_ready = rb_s;
      case (q.st)
         ST_IDLE:
         begin
            if (poll_start || q.restart)
            begin
               // every poll opens with a fresh double read
               next_q.st      = ST_RD1;
               next_q.restart = 1'b0;
               next_q.busy    = 1'b1;
               if (poll_start)
                  next_q.addr = user_addr;
            end
            else if (cmd_valid)
            begin
               // window flag sampled before an added sector erase
               next_q.st      = ST_WRC;
               next_q.addr    = cmd_addr;
               next_q.rd_data = cmd_data;
               next_q.win_pre = q.window_open;
               next_q.busy    = 1'b1;
            end
            else if (win_check)
            begin
               // optional plain window check, no command before it
               next_q.st      = ST_WIN;
               next_q.win_pre = 1'b0;
               next_q.busy    = 1'b1;
            end
            else if (rd_valid)
            begin
               next_q.st   = ST_ARRAY;
               next_q.addr = user_addr;
               next_q.busy = 1'b1;
            end
         end
         ST_RD1:
            if (cyc_done)
            begin
               next_q.first = cyc_rdata;
               next_q.st    = ST_RD2;
            end
         ST_RD2:
            if (cyc_done)
            begin
               if (poll_abort)
               begin
                  // leaving mid-poll: remember to restart from the top
                  next_q.restart = 1'b1;
                  next_q.busy    = 1'b0;
                  next_q.st      = ST_IDLE;
               end
               else if (!toggling)
               begin
                  next_q.result = RES_OK;
                  next_q.st     = ST_DONE;
               end
               else if (cyc_rdata[POS_TLIMIT])
               begin
                  next_q.first = cyc_rdata;
                  next_q.st    = ST_RD3;
               end
               else
                  next_q.first = cyc_rdata;
            end
         ST_RD3:
            if (cyc_done)
            begin
               if (toggling)
               begin
                  next_q.result = RES_FAIL;
                  next_q.st     = ST_RST;
               end
               else
               begin
                  next_q.result = RES_OK;
                  next_q.st     = ST_DONE;
               end
            end
         ST_RST:
            if (cyc_done)
               next_q.st = ST_DONE;
         ST_WRC:
            if (cyc_done)
               next_q.st = ST_WIN;
         ST_WIN:
            if (cyc_done)
            begin
               // flag high means erase began and further commands are ignored
               next_q.window_open = ~cyc_rdata[POS_WINDOW];
               // rejected only when the window was open before the added erase
               next_q.result      = (cyc_rdata[POS_WINDOW] && q.win_pre) ? RES_REJ : RES_OK;
               next_q.rd_data     = cyc_rdata;
               next_q.st          = ST_DONE;
            end
         ST_ARRAY:
            if (cyc_done)
            begin
               next_q.rd_data = cyc_rdata;
               next_q.result  = RES_NONE;
               next_q.st      = ST_DONE;
            end
         ST_DONE:
         begin
            next_q.done    = 1'b1;
            next_q.busy    = 1'b0;
            next_q.rd_data = (q.result == RES_NONE) ? q.rd_data : q.rd_data;
            next_q.st      = ST_IDLE;
         end
         default:
            next_q.st = ST_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         q             <= '0;
         q.st          <= ST_IDLE;
         q.result      <= RES_OK;
         q.flash_ready <= 1'b1;
      end
      else
         q <= next_q;
   end

   // outputs: engine outputs are flops inside the engine
   assign flash_ce_n  = pins.ce_n;
   assign flash_oe_n  = pins.oe_n;
   assign flash_we_n  = pins.we_n;
   assign flash_addr  = pins.addr;
   assign dq_out      = pins.dq_out;
   assign dq_oe       = pins.dq_oe;
   assign busy        = q.busy;
   assign done        = q.done;
   assign result      = q.result;
   assign rd_data     = q.rd_data;
   assign window_open = q.window_open;
   assign flash_ready = q.flash_ready;
endmodule
`default_nettype wire

// ==== src/fsr_pkg.sv ====
// package: constants, states and carriers for the flash status polling controller
package fsr_pkg;
   // bus widths of the flash side
   localparam int ADDR_W = 22;
   localparam int DATA_W = 8;
   // status bit positions within the status byte
   localparam int POS_POLLED  = 7;
   localparam int POS_TOGGLE  = 6;
   localparam int POS_TLIMIT  = 5;
   localparam int POS_WINDOW  = 3;
   localparam int POS_SECTOG  = 2;
   // read/write strobe phase length in mclk cycles (25 ns each)
   localparam int STROBE_NS  = 100;
   localparam int CLK_NS     = 25;
   localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS + CLK_NS - 1) / CLK_NS);
   // erase window guard: host must issue added sector erases within this time
   localparam int WINDOW_US  = 50;
   localparam int WINDOW_CYC_I = (WINDOW_US * 1000) / CLK_NS;
   // reset command data byte
   localparam logic [7:0] RESET_CMD = 8'hF0;
   // values after reset
   localparam logic [3:0] CNT_RST = 4'h0;

   // controller states, gray in the order listed
   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0000,
      ST_RD1   = 4'b0001,
      ST_RD2   = 4'b0011,
      ST_RD3   = 4'b0010,
      ST_WIN   = 4'b0110,
      ST_RST   = 4'b0111,
      ST_DONE  = 4'b0101,
      ST_ARRAY = 4'b0100,
      ST_WRC   = 4'b1100
   } fsr_state_e;

   // outcome codes
   typedef enum logic [1:0] {
      RES_OK   = 2'b00,
      RES_FAIL = 2'b01,
      RES_REJ  = 2'b10,
      RES_NONE = 2'b11
   } fsr_result_e;

   // flash pin group driven by the controller
   typedef struct packed {
      logic              ce_n;
      logic              oe_n;
      logic              we_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dq_out;
      logic              dq_oe;
   } fsr_pins_s;
endpackage

// ==== src/fsr_cycle.sv ====
// single bus cycle engine: one timed read or write strobe on the flash pins
`timescale 1ns/1ps
`default_nettype none
module fsr_cycle
   import fsr_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              rst,
   input  wire logic              start,
   input  wire logic              write,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wdata,
   input  wire logic [DATA_W-1:0] dq_sync,
   output var  fsr_pins_s         pins,
   output logic [DATA_W-1:0]      rdata,
   output logic                   done
);
   // whole state of the engine
   typedef struct packed {
      fsr_pins_s         pins;
      logic [DATA_W-1:0] rdata;
      logic              done;
      logic              busy;
      logic [3:0]        cnt;
   } fsr_cyc_s;

   fsr_cyc_s q;        // registered state
   fsr_cyc_s next_q;   // next state

   ////////////////////////////////////////////////////////////////////////
   // strobe timing
   always_comb
   begin
      next_q      = q;
      next_q.done = 1'b0;
      if (!q.busy && start)
      begin
         // open a cycle: address and strobes together, data driven on writes
         next_q.busy        = 1'b1;
         next_q.cnt         = STROBE_CYC;
         next_q.pins.addr   = addr;
         next_q.pins.ce_n   = 1'b0;
         next_q.pins.oe_n   = write;
         next_q.pins.we_n   = ~write;
         next_q.pins.dq_out = wdata;
         next_q.pins.dq_oe  = write;
      end
      else if (q.busy)
      begin
         if (q.cnt != CNT_RST)
            next_q.cnt = q.cnt - 4'h1;
         else
         begin
            // sample before strobes rise; synced data lags two cycles, covered by width
            if (!q.pins.oe_n)
               next_q.rdata = dq_sync;
            next_q.pins.ce_n  = 1'b1;
            next_q.pins.oe_n  = 1'b1;
            next_q.pins.we_n  = 1'b1;
            next_q.pins.dq_oe = 1'b0;
            next_q.busy       = 1'b0;
            next_q.done       = 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         q            <= '0;
         q.pins.ce_n  <= 1'b1;
         q.pins.oe_n  <= 1'b1;
         q.pins.we_n  <= 1'b1;
      end
      else
         q <= next_q;
   end

   assign pins  = q.pins;
   assign rdata = q.rdata;
   assign done  = q.done;
endmodule
`default_nettype wire

// ==== tb/fsr_poller_sva.sv ====
// assertion checker on the status polling controller ports
`timescale 1ns/1ps
`default_nettype none
module fsr_poller_sva
   import fsr_pkg::*;
(
   input wire logic              mclk,
   input wire logic              rst,
   input wire logic              flash_ce_n,
   input wire logic              flash_oe_n,
   input wire logic              flash_we_n,
   input wire logic [ADDR_W-1:0] flash_addr,
   input wire logic [DATA_W-1:0] dq_out,
   input wire logic              dq_oe,
   input wire logic              busy,
   input wire logic              done,
   input wire logic [1:0]        result,
   input wire logic              ready_busy_in,
   input wire logic              flash_ready
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////
   logic [3:0]        reads;   // read strobes in the current job
   logic [DATA_W-1:0] last_wr; // last byte written to the flash
   logic              busy_q;  // busy one cycle back
   // job bookkeeping
   always_ff @(posedge mclk)
   begin
      busy_q <= busy;
      if (rst)
         reads <= 4'h0;
      else if (busy && !busy_q)
         reads <= 4'h0;
      else if ($fell(flash_oe_n) && reads != 4'hF)
         reads <= reads + 4'h1;
      if (!flash_we_n)
         last_wr <= dq_out;
   end
   ////////////////////////////////////////////////////////////////
   a_rd_quiet: assert property ($fell(flash_oe_n) |-> !flash_ce_n && flash_we_n && !dq_oe)
      else $error("read strobe with write or drive active");
   a_rd_width: assert property ($fell(flash_oe_n) |-> (!flash_oe_n) [*4])
      else $error("read strobe too short");
   a_rd_addr: assert property (!flash_oe_n && $past(!flash_oe_n) |-> $stable(flash_addr))
      else $error("address moved inside a read");
   a_wr_no_rd: assert property (!flash_we_n |-> flash_oe_n && dq_oe)
      else $error("write strobe without drive or with read");
   a_fail_reset: assert property (done && result == RES_FAIL |-> last_wr == RESET_CMD)
      else $error("failure reported without reset command");
   a_fail_reads: assert property (done && result == RES_FAIL |-> reads >= 4'h3)
      else $error("failure reported before third read");
   a_idle_quiet: assert property (!busy && !busy_q |-> flash_ce_n && !dq_oe)
      else $error("flash touched while idle");
   a_ready_sync: assert property (!$past(rst, 1) && !$past(rst, 2) && !$past(rst, 3)
      |-> flash_ready == $past(ready_busy_in, 3))
      else $error("ready flag does not follow pin");
   a_busy_hold: assert property ($rose(busy) |-> busy [*6])
      else $error("job shorter than one bus cycle");
endmodule
`default_nettype wire

// ==== tb/fsr_flash_model.sv ====
// behavioural flash device answering status and array reads
`timescale 1ns/1ps
`default_nettype none
module fsr_flash_model
   import fsr_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              load,
   input  wire logic              ld_sts,
   input  wire logic [7:0]        ld_tog,
   input  wire logic              ld_tlim,
   input  wire logic              ld_win,
   input  wire logic              win_late,
   input  wire logic              ce_n,
   input  wire logic              oe_n,
   input  wire logic              we_n,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] dq_w,
   output logic      [DATA_W-1:0] dq_rd,
   output logic                   rdy
);
   logic       sts = 1'b0;   // status mode, else array data
   logic [7:0] tog = 8'h00;  // reads still to toggle
   logic       tgl = 1'b0;   // toggle bit value
   logic       tlim = 1'b0;  // time limit flag
   logic       win = 1'b0;   // erase window flag
   logic [7:0] last = 8'h00; // last byte shown
   logic       rd_q = 1'b0;
   logic       we_q = 1'b1;
   logic       rd;
   logic [7:0] val;
   // polled bit 0 while erasing, sector toggle follows toggle bit
   assign rd = !ce_n && !oe_n;
   assign val = sts ? {(tog == 8'h00), tgl, tlim, 1'b0, win, tgl, 2'b00} : (addr[7:0] ^ 8'hA5);
   // released bus shows the inverse so stale data never passes
   assign dq_rd = rd ? val : ~last;
   assign rdy = (tog == 8'h00);
   ////////////////////////////////////////////////////////////////
   // state moves at strobe ends
   always @(posedge mclk)
   begin
      rd_q <= rd;
      we_q <= we_n;
      if (rd)
         last <= val;
      // suspend, partial protection and halted program reduce to a count and a flag
      if (load)
      begin
         {sts, tog, tlim, win} <= {ld_sts, ld_tog, ld_tlim, ld_win};
      end
      else if (rd_q && !rd && tog != 8'h00)
      begin
         tgl <= !tgl;
         tog <= tog - 8'h01;
      end
      else if (we_n && !we_q)
      begin
         if (dq_w == RESET_CMD)
            {sts, tog, tlim} <= 10'h000;
         else
            win <= win_late;
      end
   end
endmodule
`default_nettype wire

// ==== tb/fsr_poller_test.sv ====
// self-checking bench: poller against a flash model
`timescale 1ns/1ps
`default_nettype none
module fsr_poller_test
   import fsr_pkg::*;
;
   typedef struct packed {logic [1:0] res; logic [7:0] dat; logic cr; logic cd;} fsr_note_s;
   logic              mclk, rst, poll_start, poll_abort, win_check, cmd_valid, rd_valid;
   logic [ADDR_W-1:0] cmd_addr, user_addr, flash_addr;
   logic [DATA_W-1:0] cmd_data, dq_in, dq_out, rd_data;
   logic              ce_n, oe_n, we_n, dq_oe, busy, done, window_open, flash_ready, rdy;
   logic [1:0]        result;
   logic              load, ld_sts, ld_tlim, ld_win, win_late;
   logic [7:0]        ld_tog;
   int                failures = 0, checks_done = 0, cycles = 0;
   fsr_note_s         notes[$];
   fsr_note_s         head;
   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   fsr_poller fsr_poller_i (.mclk(mclk), .rst(rst), .poll_start(poll_start), .poll_abort(poll_abort),
      .win_check(win_check), .cmd_valid(cmd_valid), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
      .rd_valid(rd_valid), .user_addr(user_addr), .dq_in(dq_in), .ready_busy_in(rdy),
      .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_addr(flash_addr),
      .dq_out(dq_out), .dq_oe(dq_oe), .busy(busy), .done(done), .result(result),
      .rd_data(rd_data), .window_open(window_open), .flash_ready(flash_ready));
   fsr_flash_model fsr_flash_model_i (.mclk(mclk), .load(load), .ld_sts(ld_sts), .ld_tog(ld_tog),
      .ld_tlim(ld_tlim), .ld_win(ld_win), .win_late(win_late), .ce_n(ce_n), .oe_n(oe_n),
      .we_n(we_n), .addr(flash_addr), .dq_w(dq_out), .dq_rd(dq_in), .rdy(rdy));
   ////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // load the flash model state for the next scenario
   task automatic dev(input logic s, input logic [7:0] t, input logic tl, input logic w, input logic wl);
      @(posedge mclk);
      #2;
      {ld_sts, ld_tog, ld_tlim, ld_win, win_late, load} = {s, t, tl, w, wl, 1'b1};
      @(posedge mclk);
      #2;
      load = 1'b0;
   endtask
   // one request pulse, note the outcome, wait for idle
   task automatic job(input int kind, input fsr_note_s n);
      int k;
      notes.push_back(n);
      @(posedge mclk);
      #2;
      {poll_start, cmd_valid, win_check, rd_valid} = 4'h8 >> kind;
      @(posedge mclk);
      #2;
      {poll_start, cmd_valid, win_check, rd_valid} = 4'h0;
      k = 0;
      while (busy !== 1'b0 && k < 4000)
      begin
         @(posedge mclk);
         #2;
         k++;
      end
   endtask
   ////////////////////////////////////////////////////////////////
   // outcome watcher: oldest note against each done
   always @(posedge mclk)
   begin
      if (done === 1'b1)
      begin
         if (notes.size() == 0)
            check("unexpected done", 8'h00, 8'h01);
         else
         begin
            head = notes.pop_front();
            if (head.cr)
               check("result", {6'h00, head.res}, {6'h00, result});
            if (head.cd)
               check("rd_data", head.dat, rd_data);
         end
      end
   end
   // hang guard
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         failures++;
         end_of_test();
      end
   end
   ////////////////////////////////////////////////////////////////
   initial
   begin
      {rst, poll_start, win_check, cmd_valid, rd_valid, load} = 6'h20;
      poll_abort = 1'b0;
      {ld_sts, ld_tog, ld_tlim, ld_win, win_late} = 12'h000;
      {cmd_addr, user_addr, cmd_data} = '0;
      void'($urandom(20));
      repeat (2) @(posedge mclk);
      #2;
      rst = 1'b0;
      check("idle strobes", 8'h07, {5'h00, ce_n, oe_n, we_n});
      check("ready flag", 8'h01, {7'h00, flash_ready});
      for (int i = 0; i < 3; i++)
      begin
         user_addr = ADDR_W'($urandom);
         job(3, '{2'h3, user_addr[7:0] ^ 8'hA5, 1'b1, 1'b1});
      end
      dev(1'b1, 8'h00, 1'b0, 1'b0, 1'b0);
      job(0, '{2'h0, 8'h00, 1'b1, 1'b0});
      dev(1'b1, 8'h05, 1'b0, 1'b0, 1'b0);
      repeat (5) @(posedge mclk);
      check("busy pin seen", 8'h00, {7'h00, flash_ready});
      job(0, '{2'h0, 8'h00, 1'b1, 1'b0});
      check("ready again", 8'h01, {7'h00, flash_ready});
      // abort after the first double read, then let the restarted poll finish
      dev(1'b1, 8'h14, 1'b0, 1'b0, 1'b0);
      poll_abort = 1'b1;
      job(0, '{2'h0, 8'h00, 1'b1, 1'b0});
      poll_abort = 1'b0;
      @(posedge mclk);
      #2;
      while (busy !== 1'b0)
      begin
         @(posedge mclk);
         #2;
      end
      check("ready after restart", 8'h01, {7'h00, flash_ready});
      dev(1'b1, 8'h01, 1'b1, 1'b0, 1'b0);
      job(0, '{2'h0, 8'h00, 1'b1, 1'b0});
      dev(1'b1, 8'hC8, 1'b1, 1'b0, 1'b0);
      job(0, '{2'h1, 8'h00, 1'b1, 1'b0});
      repeat (5) @(posedge mclk);
      check("ready after reset cmd", 8'h01, {7'h00, flash_ready});
      dev(1'b1, 8'h00, 1'b0, 1'b0, 1'b1);
      job(2, '{2'h0, 8'h00, 1'b1, 1'b0});
      check("window open", 8'h01, {7'h00, window_open});
      {cmd_addr, cmd_data} = {ADDR_W'($urandom), 8'h30};
      job(1, '{2'h2, 8'h00, 1'b1, 1'b0});
      check("window closed", 8'h00, {7'h00, window_open});
      dev(1'b1, 8'h00, 1'b0, 1'b0, 1'b0);
      job(2, '{2'h0, 8'h00, 1'b1, 1'b0});
      job(1, '{2'h0, 8'h00, 1'b1, 1'b0});
      end_of_test();
   end
endmodule
bind fsr_poller fsr_poller_sva fsr_poller_sva_i (.mclk(mclk), .rst(rst), .flash_ce_n(flash_ce_n),
   .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_addr(flash_addr), .dq_out(dq_out),
   .dq_oe(dq_oe), .busy(busy), .done(done), .result(result), .ready_busy_in(ready_busy_in),
   .flash_ready(flash_ready));
`default_nettype wire
